// File: core/dbg_cmd_pkg.sv
package dbg_cmd_pkg;
    localparam logic [7:0] OP_BREAKPOINT  = 8'h00;
    localparam logic [7:0] OP_READ_REG    = 8'h09;
    localparam logic [7:0] OP_WRITE_PROG  = 8'h0A;
    localparam logic [7:0] OP_READ_PROG   = 8'h0B;
    localparam logic [7:0] OP_WRITE_DATA  = 8'h0C;
    localparam logic [7:0] FILL_BYTE      = 8'hFF;
    localparam logic [3:0] REG_ADDR_PAD   = 4'h0;
    localparam int         FIFO_WIDTH     = 8;
    localparam int         FIFO_DEPTH     = 32;
    localparam logic [16:0] REG_SIZE_WRAP = 17'h00100;
    localparam logic [16:0] MEM_SIZE_WRAP = 17'h10000;

    typedef enum logic [1:0] {
        MEM_REG,
        MEM_PROG,
        MEM_DATA
    } mem_space_e;
endpackage

// File: core/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_ff != rd_ptr_ff;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_ff <= '0;
        end else if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_ptr_ff <= '0;
        end else if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

// File: core/debug_command_port.sv
`timescale 1ns/1ps
module debug_command_port #(
    parameter int FIFO_DEPTH = dbg_cmd_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic        cpu_halted,
    input  wire logic        cpu_at_loop_break,
    input  wire logic [7:0]  cpu_fetch_opcode,
    input  wire logic        cpu_fetch_valid,
    output logic             breakpoint_instruction,
    input  wire logic        break_loop_enable,
    input  wire logic        debug_mode_set,
    input  wire logic        debug_mode_clear,
    output logic             debug_mode_flag,
    input  wire logic        read_protect_option,
    input  wire logic        flash_unlocked,
    output logic             mem_req,
    output logic             mem_we,
    output dbg_cmd_pkg::mem_space_e mem_space,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("fifo depth too small");
        end
    end

    typedef enum {
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_SIZE_HI,
        ST_SIZE_LO,
        ST_WR_DATA,
        ST_WR_MEM,
        ST_RD_MEM,
        ST_RD_PUSH
    } state_e;

    state_e               state_ff;
    logic [7:0]           opcode_ff;
    logic [15:0]          addr_ff;
    logic [16:0]          count_ff;
    logic [7:0]           wbyte_ff;
    logic [7:0]           rbyte_ff;
    logic                 allowed;
    logic                 take;
    logic                 is_known;
    logic [7:0]           f_in_data;
    logic                 f_in_valid;
    logic                 f_in_ready;

    // commands here are all gated; host must halt the cpu in debug mode first
    assign allowed = debug_mode_flag && cpu_halted && !read_protect_option;
    assign is_known = rx_data == dbg_cmd_pkg::OP_READ_REG
                   || rx_data == dbg_cmd_pkg::OP_WRITE_PROG
                   || rx_data == dbg_cmd_pkg::OP_READ_PROG
                   || rx_data == dbg_cmd_pkg::OP_WRITE_DATA;

    always_comb begin
        case (state_ff)
            ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO,
            ST_SIZE_HI, ST_SIZE_LO, ST_WR_DATA: rx_ready = 1'b1;
            default:                            rx_ready = 1'b0;
        endcase
    end
    assign take = rx_valid && rx_ready;

    function automatic logic [16:0] size_of(input logic [15:0] raw, input logic [16:0] wrap);
        size_of = (raw == 16'h0000) ? wrap : {1'b0, raw};
    endfunction

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff  <= ST_OPCODE;
            opcode_ff <= 8'h00;
            addr_ff   <= 16'h0000;
            count_ff  <= 17'h00000;
            wbyte_ff  <= 8'h00;
        end else begin
            case (state_ff)
                ST_OPCODE: if (take && is_known) begin
                    opcode_ff <= rx_data;
                    state_ff  <= ST_ADDR_HI;
                end
                ST_ADDR_HI: if (take) begin
                    if (opcode_ff == dbg_cmd_pkg::OP_READ_REG) begin
                        addr_ff[15:8] <= {dbg_cmd_pkg::REG_ADDR_PAD, rx_data[3:0]};
                    end else begin
                        addr_ff[15:8] <= rx_data;
                    end
                    state_ff <= ST_ADDR_LO;
                end
                ST_ADDR_LO: if (take) begin
                    addr_ff[7:0] <= rx_data;
                    if (opcode_ff == dbg_cmd_pkg::OP_READ_REG) begin
                        count_ff <= 17'h00000;
                        state_ff <= ST_SIZE_LO;  // one size byte
                    end else begin
                        state_ff <= ST_SIZE_HI;
                    end
                end
                ST_SIZE_HI: if (take) begin
                    count_ff <= {1'b0, rx_data, 8'h00};
                    state_ff <= ST_SIZE_LO;
                end
                ST_SIZE_LO: if (take) begin
                    if (opcode_ff == dbg_cmd_pkg::OP_READ_REG) begin
                        count_ff <= size_of({8'h00, rx_data}, dbg_cmd_pkg::REG_SIZE_WRAP);
                        state_ff <= ST_RD_MEM;
                    end else if (opcode_ff == dbg_cmd_pkg::OP_READ_PROG) begin
                        count_ff <= size_of({count_ff[15:8], rx_data},
                                            dbg_cmd_pkg::MEM_SIZE_WRAP);
                        state_ff <= ST_RD_MEM;
                    end else begin
                        count_ff <= size_of({count_ff[15:8], rx_data},
                                            dbg_cmd_pkg::MEM_SIZE_WRAP);
                        state_ff <= ST_WR_DATA;
                    end
                end
                ST_WR_DATA: if (take) begin
                    wbyte_ff <= rx_data;
                    // blocked writes still consume every data byte
                    if (!allowed) begin
                        count_ff <= count_ff - 17'h00001;
                        state_ff <= (count_ff == 17'h00001) ? ST_OPCODE : ST_WR_DATA;
                    end else if (opcode_ff == dbg_cmd_pkg::OP_WRITE_PROG && !flash_unlocked) begin
                        count_ff <= count_ff - 17'h00001;
                        state_ff <= (count_ff == 17'h00001) ? ST_OPCODE : ST_WR_DATA;
                    end else begin
                        state_ff <= ST_WR_MEM;
                    end
                end
                ST_WR_MEM: if (mem_ack) begin
                    addr_ff  <= addr_ff + 16'h0001;
                    count_ff <= count_ff - 17'h00001;
                    state_ff <= (count_ff == 17'h00001) ? ST_OPCODE : ST_WR_DATA;
                end
                ST_RD_MEM: if (!allowed || mem_ack) begin
                    state_ff <= ST_RD_PUSH;
                end
                ST_RD_PUSH: if (f_in_ready) begin
                    addr_ff  <= addr_ff + 16'h0001;
                    count_ff <= count_ff - 17'h00001;
                    state_ff <= (count_ff == 17'h00001) ? ST_OPCODE : ST_RD_MEM;
                end
                default: state_ff <= ST_OPCODE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rbyte_ff <= 8'h00;
        end else if (state_ff == ST_RD_MEM) begin
            rbyte_ff <= allowed ? mem_rdata : dbg_cmd_pkg::FILL_BYTE;
        end
    end

    assign mem_req   = (state_ff == ST_WR_MEM) || (state_ff == ST_RD_MEM && allowed);
    assign mem_we    = state_ff == ST_WR_MEM;
    assign mem_addr  = addr_ff;
    assign mem_wdata = wbyte_ff;
    always_comb begin
        case (opcode_ff)
            dbg_cmd_pkg::OP_READ_REG:   mem_space = dbg_cmd_pkg::MEM_REG;
            dbg_cmd_pkg::OP_WRITE_DATA: mem_space = dbg_cmd_pkg::MEM_DATA;
            default:                    mem_space = dbg_cmd_pkg::MEM_PROG;
        endcase
    end

    // reply bytes queue here so a slow serialiser back-pressures reads
    assign f_in_data  = rbyte_ff;
    assign f_in_valid = state_ff == ST_RD_PUSH;

    byte_fifo #(
        .WIDTH (dbg_cmd_pkg::FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_data   (f_in_data),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            breakpoint_instruction <= 1'b0;
        end else begin
            breakpoint_instruction <= cpu_fetch_valid
                && cpu_fetch_opcode == dbg_cmd_pkg::OP_BREAKPOINT;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            debug_mode_flag <= 1'b0;
        end else if (debug_mode_set || (cpu_at_loop_break && !break_loop_enable)) begin
            debug_mode_flag <= 1'b1;  // set wins over clear
        end else if (debug_mode_clear) begin
            debug_mode_flag <= 1'b0;
        end
    end
endmodule

// File: dv/debug_command_port_monitor.sv
`timescale 1ns/1ps
module debug_command_port_monitor (
    input wire logic                    clk_sys,
    input wire logic                    reset,
    input wire logic [7:0]              tx_data,
    input wire logic                    tx_valid,
    input wire logic                    tx_ready,
    input wire logic                    cpu_halted,
    input wire logic                    cpu_at_loop_break,
    input wire logic [7:0]              cpu_fetch_opcode,
    input wire logic                    cpu_fetch_valid,
    input wire logic                    breakpoint_instruction,
    input wire logic                    break_loop_enable,
    input wire logic                    debug_mode_set,
    input wire logic                    debug_mode_clear,
    input wire logic                    debug_mode_flag,
    input wire logic                    read_protect_option,
    input wire logic                    flash_unlocked,
    input wire logic                    mem_req,
    input wire logic                    mem_we,
    input wire dbg_cmd_pkg::mem_space_e mem_space,
    input wire logic [15:0]             mem_addr,
    input wire logic [7:0]              mem_wdata,
    input wire logic                    mem_ack
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_brk_hit;
        cpu_fetch_valid && cpu_fetch_opcode == 8'h00 |=> breakpoint_instruction;
    endproperty
    a_brk_hit: assert property (p_brk_hit) else $error("breakpoint missed");
    property p_brk_miss;
        !(cpu_fetch_valid && cpu_fetch_opcode == 8'h00) |=> !breakpoint_instruction;
    endproperty
    a_brk_miss: assert property (p_brk_miss) else $error("false breakpoint");
    property p_loop_set;
        cpu_at_loop_break && !break_loop_enable |=> debug_mode_flag;
    endproperty
    a_loop_set: assert property (p_loop_set) else $error("debug mode not entered");
    property p_clear;
        debug_mode_clear && !debug_mode_set && !cpu_at_loop_break |=> !debug_mode_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("debug mode not left");
    property p_gate;
        mem_req |-> debug_mode_flag && cpu_halted && !read_protect_option;
    endproperty
    a_gate: assert property (p_gate) else $error("access while blocked");
    property p_flash;
        mem_req && mem_we && mem_space == dbg_cmd_pkg::MEM_PROG |-> flash_unlocked;
    endproperty
    a_flash: assert property (p_flash) else $error("flash write while locked");
    property p_req_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request moved");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte moved");
    property p_reg_space;
        mem_req && mem_space == dbg_cmd_pkg::MEM_REG |-> !mem_we && mem_addr[15:12] == 4'h0;
    endproperty
    a_reg_space: assert property (p_reg_space) else $error("bad register access");
endmodule
bind debug_command_port debug_command_port_monitor debug_command_port_monitor_inst (
    .clk_sys, .reset, .tx_data, .tx_valid, .tx_ready, .cpu_halted, .cpu_at_loop_break,
    .cpu_fetch_opcode, .cpu_fetch_valid, .breakpoint_instruction, .break_loop_enable,
    .debug_mode_set, .debug_mode_clear, .debug_mode_flag, .read_protect_option,
    .flash_unlocked, .mem_req, .mem_we, .mem_space, .mem_addr, .mem_wdata, .mem_ack);

// File: dv/debug_host.sv
`timescale 1ns/1ps
module debug_host (
    input  wire logic       clk_sys,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] got_q[$];
    int         stall_pct = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // bytes leave in command order, each held until taken
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        rx_data = b;
        rx_valid = 1'b1;
        do @(posedge clk_sys); while (rx_ready !== 1'b1);
        @(negedge clk_sys);
        rx_valid = 1'b0;
        // released line shows the inverse so a stale byte cannot pass
        rx_data = ~b;
    endtask
    always @(negedge clk_sys) tx_ready = $urandom_range(99) >= stall_pct;
    always @(posedge clk_sys) if (tx_valid === 1'b1 && tx_ready) got_q.push_back(tx_data);
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk_sys, reset, rx_valid, rx_ready, tx_valid, tx_ready, cpu_halted;
    logic        cpu_at_loop_break, cpu_fetch_valid, breakpoint_instruction, mem_ack;
    logic        break_loop_enable, debug_mode_set, debug_mode_clear, debug_mode_flag;
    logic        read_protect_option, flash_unlocked, mem_req, mem_we, mode_exp;
    logic [7:0]  rx_data, tx_data, cpu_fetch_opcode, mem_wdata, mem_rdata;
    logic [15:0] mem_addr;
    logic [25:0] wr_q[$];
    int          num_errors = 0;
    int          total_checks = 0;
    int          n;
    dbg_cmd_pkg::mem_space_e mem_space;
    debug_command_port debug_command_port_inst (.clk_sys, .reset, .rx_data, .rx_valid,
        .rx_ready, .tx_data, .tx_valid, .tx_ready, .cpu_halted, .cpu_at_loop_break,
        .cpu_fetch_opcode, .cpu_fetch_valid, .breakpoint_instruction, .break_loop_enable,
        .debug_mode_set, .debug_mode_clear, .debug_mode_flag, .read_protect_option,
        .flash_unlocked, .mem_req, .mem_we, .mem_space, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata);
    debug_host debug_host_inst (.clk_sys, .rx_data, .rx_valid, .rx_ready, .tx_data,
        .tx_valid, .tx_ready);
    function automatic logic [7:0] mem_val(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3C;
    endfunction
    // memory answers at random delay; idle read data keeps toggling
    always @(negedge clk_sys) begin
        mem_ack = mem_req && ($urandom_range(2) == 0);
        mem_rdata = mem_ack ? mem_val(mem_addr) : ~mem_rdata;
    end
    always @(posedge clk_sys) if (mem_req && mem_ack && mem_we)
        wr_q.push_back({mem_space, mem_addr, mem_wdata});
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic run_cmd(input logic [7:0] op, input logic [15:0] a, input int cnt);
        logic [7:0] d[$];
        logic [1:0] sp;
        logic       ok;
        logic       wr;
        int         ec;
        ok = mode_exp && cpu_halted && !read_protect_option && (op != 8'h0A || flash_unlocked);
        wr = op inside {8'h0A, 8'h0C};
        sp = (op == 8'h0A) ? dbg_cmd_pkg::MEM_PROG : dbg_cmd_pkg::MEM_DATA;
        ec = (wr && !ok) ? 0 : cnt;
        wr_q.delete();
        debug_host_inst.got_q.delete();
        debug_host_inst.send(op);
        debug_host_inst.send(a[15:8]);
        debug_host_inst.send(a[7:0]);
        if (op != 8'h09) debug_host_inst.send(8'(cnt >> 8));
        debug_host_inst.send(8'(cnt));
        for (int i = 0; i < cnt && wr; i++) begin
            d.push_back(8'($urandom));
            debug_host_inst.send(d[i]);
        end
        for (int k = 0; k < 3000 && (wr ? wr_q.size() : debug_host_inst.got_q.size()) < ec; k++)
            @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        check("count", ec, wr ? wr_q.size() : debug_host_inst.got_q.size());
        for (int i = 0; i < ec; i++)
            if (wr) check("write", {sp, a + 16'(i), d[i]}, wr_q[i]);
            else check("read", ok ? mem_val(a + 16'(i)) : 8'hFF, debug_host_inst.got_q[i]);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #500000;
        num_errors++;
        stop_test();
    end
    initial begin
        {reset, cpu_halted, cpu_at_loop_break, cpu_fetch_valid, break_loop_enable} = 5'h11;
        {debug_mode_set, debug_mode_clear, read_protect_option, flash_unlocked} = 4'h0;
        {cpu_fetch_opcode, mode_exp} = 9'h000;
        void'($urandom(32'hB395AFD1));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        // host only plants breakpoints; lifting one is a page erase and rewrite
        pulse(cpu_fetch_valid);
        check("brk", 1, breakpoint_instruction);
        cpu_fetch_opcode = 8'h0A;
        pulse(cpu_fetch_valid);
        check("brk", 0, breakpoint_instruction);
        run_cmd(8'h09, 16'h0123, 4);
        debug_host_inst.send(8'h55);
        run_cmd(8'h0B, 16'hFFFE, 3);
        pulse(cpu_at_loop_break);
        check("mode", 0, debug_mode_flag);
        break_loop_enable = 1'b0;
        pulse(cpu_at_loop_break);
        mode_exp = 1'b1;
        check("mode", 1, debug_mode_flag);
        cpu_halted = 1'b1;
        // a size of zero for 16-bit fields is left out: 65536 bytes would outrun the budget
        for (int it = 0; it < 8; it++) begin
            @(negedge clk_sys);
            read_protect_option = it == 2 || it == 6;
            cpu_halted = it != 3;
            flash_unlocked = it != 4;
            debug_host_inst.stall_pct = $urandom_range(60);
            n = it == 0 ? 256 : it == 1 ? 1 : $urandom_range(40, 1);
            run_cmd(8'h09, 16'($urandom_range(16'h0E00)), n);
            run_cmd(8'h0B, 16'($urandom), n);
            run_cmd(8'h0A, 16'($urandom), n);
            run_cmd(8'h0C, 16'($urandom), n);
        end
        pulse(debug_mode_clear);
        mode_exp = 1'b0;
        check("mode", 0, debug_mode_flag);
        run_cmd(8'h0C, 16'h1000, 5);
        stop_test();
    end
endmodule
